/* File: mlr_alu.sv */
// combinational result, destination and flag logic per opcode
// assumes the core applies the enables in the execute cycle
module mlr_alu
  import mlr_pkg::*;
(
  mlr_alu_if.alu  a
);
  logic [DW:0]   sub_sum;
  logic [4:0]    sub_low;
  logic [DW-1:0] inv_mem;
  logic [DW-1:0] dec_mem;

  assign inv_mem = ~a.mem;
  assign dec_mem = a.mem - 8'h01;
  assign sub_sum = {1'b0, a.acc} + {1'b0, inv_mem} + {8'h00, a.c_in};
  assign sub_low = {1'b0, a.acc[3:0]} + {1'b0, inv_mem[3:0]}
                   + {4'h0, a.c_in};
  assign a.zero  = (a.res == 8'h00);

  always_comb begin
    a.res       = a.acc;
    a.acc_wr    = 1'b0;
    a.mem_wr    = 1'b0;
    a.upd_c     = 1'b0;
    a.upd_z     = 1'b0;
    a.upd_arith = 1'b0;
    a.c_out     = a.c_in;
    a.hc_out    = sub_low[4];
    a.sx_out    = (a.acc[7] == inv_mem[7]) && (sub_sum[7] != a.acc[7]);
    a.valid_op  = 1'b1;
    case (a.op)
      OP_MOV_A_M: begin a.res = a.mem; a.acc_wr = 1'b1; end
      OP_MOV_A_X: begin a.res = a.imm; a.acc_wr = 1'b1; end
      OP_MOV_M_A: begin a.res = a.acc; a.mem_wr = 1'b1; end
      OP_NOP, OP_RET, OP_RET_INT: a.res = a.acc;
      OP_RET_A_X: begin a.res = a.imm; a.acc_wr = 1'b1; end
      OP_OR_A_M: begin
        a.res = a.acc | a.mem; a.acc_wr = 1'b1; a.upd_z = 1'b1;
      end
      OP_OR_A_X: begin
        a.res = a.acc | a.imm; a.acc_wr = 1'b1; a.upd_z = 1'b1;
      end
      OP_OR_M_A: begin
        a.res = a.acc | a.mem; a.mem_wr = 1'b1; a.upd_z = 1'b1;
      end
      OP_RL: begin
        a.res = {a.mem[6:0], a.mem[7]}; a.mem_wr = 1'b1;
      end
      OP_RL_A: begin
        a.res = {a.mem[6:0], a.mem[7]}; a.acc_wr = 1'b1;
      end
      OP_RL_C: begin
        a.res = {a.mem[6:0], a.c_in}; a.mem_wr = 1'b1;
        a.upd_c = 1'b1; a.c_out = a.mem[7];
      end
      OP_RL_CA: begin
        a.res = {a.mem[6:0], a.c_in}; a.acc_wr = 1'b1;
        a.upd_c = 1'b1; a.c_out = a.mem[7];
      end
      OP_RR: begin
        a.res = {a.mem[0], a.mem[7:1]}; a.mem_wr = 1'b1;
      end
      OP_RR_A: begin
        a.res = {a.mem[0], a.mem[7:1]}; a.acc_wr = 1'b1;
      end
      OP_RR_C: begin
        a.res = {a.c_in, a.mem[7:1]}; a.mem_wr = 1'b1;
        a.upd_c = 1'b1; a.c_out = a.mem[0];
      end
      OP_RR_CA: begin
        a.res = {a.c_in, a.mem[7:1]}; a.acc_wr = 1'b1;
        a.upd_c = 1'b1; a.c_out = a.mem[0];
      end
      OP_SUB_B: begin
        a.res = sub_sum[7:0]; a.acc_wr = 1'b1; a.c_out = sub_sum[8];
        a.upd_c = 1'b1; a.upd_z = 1'b1; a.upd_arith = 1'b1;
      end
      OP_SUB_B_M: begin
        a.res = sub_sum[7:0]; a.mem_wr = 1'b1; a.c_out = sub_sum[8];
        a.upd_c = 1'b1; a.upd_z = 1'b1; a.upd_arith = 1'b1;
      end
      OP_DEC_SKZ: begin a.res = dec_mem; a.mem_wr = 1'b1; end
      default: a.valid_op = 1'b0;
    endcase
  end
endmodule : mlr_alu

/* File: mlr_alu_if.sv */
// operand and result bundle between the core and its datapath
// assumes the datapath is purely combinational
interface mlr_alu_if;
  import mlr_pkg::*;
  mlr_op_t        op;
  logic [DW-1:0]  acc;
  logic [DW-1:0]  mem;
  logic [DW-1:0]  imm;
  logic           c_in;
  logic [DW-1:0]  res;
  logic           acc_wr;
  logic           mem_wr;
  logic           upd_c;
  logic           upd_z;
  logic           upd_arith;
  logic           c_out;
  logic           hc_out;
  logic           sx_out;
  logic           zero;
  logic           valid_op;
  modport core (output op, acc, mem, imm, c_in,
                input res, acc_wr, mem_wr, upd_c, upd_z, upd_arith,
                      c_out, hc_out, sx_out, zero, valid_op);
  modport alu  (input op, acc, mem, imm, c_in,
                output res, acc_wr, mem_wr, upd_c, upd_z, upd_arith,
                       c_out, hc_out, sx_out, zero, valid_op);
endinterface : mlr_alu_if

/* File: mlr_axi_master.sv */
// axi4-lite master model standing at the register port of the core
// assumes one caller at a time; bready and rready stay high throughout
module mlr_axi_master (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
    bready = 1'b1;
    rready = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released payload shows the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
  endtask : rd
endmodule : mlr_axi_master

/* File: mlr_exec_core.sv */
// execute core with data memory, return stack and an AXI4-Lite slave
// assumes a single-beat AXI4-Lite master on aclk, synchronous reset
module mlr_exec_core
  import mlr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DW-1:0]  acc;
  logic           flag_c, flag_hc, flag_z, flag_sx, gie;
  logic [PCW-1:0] pc;
  logic [MAW-1:0] maddr;
  logic [DW-1:0]  dmem [DMEM_DEPTH];
  logic [PCW-1:0] stk  [STK_DEPTH];
  logic [SPW-1:0] sp;
  logic [1:0]     cycles;
  logic           skipped;
  mlr_state_t     state;

  // write and read address channel holding
  logic        aw_got, w_got, ar_got;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        next_aw_got, next_w_got, next_ar_got;

  mlr_alu_if alu_bus ();
  mlr_alu u_alu (.a(alu_bus));

  ////////////////////////////////////////////////////////////////////////////
  // write address/data acceptance, either order
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire b_hs   = s_axi_bvalid & s_axi_bready;
  wire ar_hs  = s_axi_arvalid & s_axi_arready;
  wire r_hs   = s_axi_rvalid & s_axi_rready;
  wire wr_fire = aw_got & w_got & ~s_axi_bvalid;

  assign next_aw_got = aw_hs ? 1'b1 : (b_hs ? 1'b0 : aw_got);
  assign next_w_got  = w_hs  ? 1'b1 : (b_hs ? 1'b0 : w_got);
  assign next_ar_got = ar_hs ? 1'b1 : (r_hs ? 1'b0 : ar_got);

  // byte lanes merge into the old value; the instruction word merges into zero
  wire [31:0] lane_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                           {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  wire [31:0] status_word = {22'h00_0000, skipped,
                             (state == ST_DUMMY), 3'h0, gie,
                             flag_sx, flag_z, flag_hc, flag_c};
  wire [31:0] st_new  = merge(status_word, wdata_q, lane_mask);
  wire [31:0] acc_new = merge({24'h00_0000, acc}, wdata_q, lane_mask);
  wire [31:0] pc_new  = merge({20'h0_0000, pc}, wdata_q, lane_mask);
  wire [31:0] ins_new = merge(32'h0000_0000, wdata_q, lane_mask);

  wire sel_instr  = (awaddr_q == OFS_INSTR);
  wire sel_acc    = (awaddr_q == OFS_ACC);
  wire sel_status = (awaddr_q == OFS_STATUS);
  wire sel_pc     = (awaddr_q == OFS_PC);
  wire sel_maddr  = (awaddr_q == OFS_MADDR);
  wire sel_mdata  = (awaddr_q == OFS_MDATA);
  wire sel_stack  = (awaddr_q == OFS_STACK);
  wire sel_cyc    = (awaddr_q == OFS_CYCLES);
  wire wr_mapped  = sel_instr | sel_acc | sel_status | sel_pc | sel_maddr
                    | sel_mdata | sel_stack | sel_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode and execute strobe
  wire [MAW-1:0] ins_addr = ins_new[F_ADR_LSB +: MAW];
  wire           idle     = (state == ST_IDLE);
  wire           stk_full = (sp == SPW'(STK_DEPTH));
  wire           stk_empty = (sp == 4'h0);
  wire [PCW-1:0] stk_top  = stk_empty ? 12'h000 : stk[3'(sp - 4'h1)];

  assign alu_bus.op   = mlr_op_t'(ins_new[F_OP_LSB +: 5]);
  assign alu_bus.acc  = acc;
  assign alu_bus.mem  = dmem[ins_addr];
  assign alu_bus.imm  = ins_new[F_IMM_LSB +: DW];
  assign alu_bus.c_in = flag_c;

  // a busy core or an unknown opcode refuses the instruction
  wire exec     = wr_fire & sel_instr & idle & alu_bus.valid_op;
  wire is_ret   = (alu_bus.op == OP_RET) | (alu_bus.op == OP_RET_A_X)
                  | (alu_bus.op == OP_RET_INT);
  wire dec_skip = (alu_bus.op == OP_DEC_SKZ) & alu_bus.zero;
  wire two_cyc  = is_ret | dec_skip;
  wire wr_err   = sel_instr & ~(idle & alu_bus.valid_op);
  wire [1:0] next_bresp = ~wr_mapped ? RESP_DECERR :
                          (wr_err ? RESP_SLVERR : RESP_OKAY);

  // memory port: execute result or software data
  wire           dm_we = (exec & alu_bus.mem_wr) | (wr_fire & sel_mdata);
  wire [MAW-1:0] dm_wa = exec ? ins_addr : maddr;
  wire [DW-1:0]  dm_wd = exec ? alu_bus.res : wdata_q[DW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0; w_got <= 1'b0; ar_got <= 1'b0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
    end else begin
      aw_got <= next_aw_got; w_got <= next_w_got; ar_got <= next_ar_got;
      s_axi_awready <= ~next_aw_got;
      s_axi_wready  <= ~next_w_got;
      s_axi_arready <= ~next_ar_got;
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_hs) awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
    if (w_hs) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] rd_word =
      (ra == OFS_ACC)    ? {24'h00_0000, acc} :
      (ra == OFS_STATUS) ? status_word :
      (ra == OFS_PC)     ? {20'h0_0000, pc} :
      (ra == OFS_MADDR)  ? {26'h000_0000, maddr} :
      (ra == OFS_MDATA)  ? {24'h00_0000, dmem[maddr]} :
      (ra == OFS_STACK)  ? {28'h000_0000, sp} :
      (ra == OFS_CYCLES) ? {30'h0000_0000, cycles} : 32'h0000_0000;
  wire rd_mapped = (ra == OFS_INSTR) | (ra == OFS_ACC) | (ra == OFS_STATUS)
                   | (ra == OFS_PC) | (ra == OFS_MADDR) | (ra == OFS_MDATA)
                   | (ra == OFS_STACK) | (ra == OFS_CYCLES);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (r_hs) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 8'h00;
    end else if (exec && alu_bus.acc_wr) begin
      acc <= alu_bus.res;
    end else if (wr_fire && sel_acc) begin
      acc <= acc_new[DW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_c <= 1'b0; flag_hc <= 1'b0; flag_z <= 1'b0; flag_sx <= 1'b0;
    end else if (exec) begin
      if (alu_bus.upd_c) flag_c <= alu_bus.c_out;
      if (alu_bus.upd_z) flag_z <= alu_bus.zero;
      if (alu_bus.upd_arith) begin
        flag_hc <= alu_bus.hc_out;
        flag_sx <= alu_bus.sx_out;
      end
    end else if (wr_fire && sel_status) begin
      flag_c  <= st_new[S_C];  flag_hc <= st_new[S_HC];
      flag_z  <= st_new[S_Z];  flag_sx <= st_new[S_SX];
    end
  end

  // interrupt return sets the enable; software may clear it
  always_ff @(posedge aclk) begin
    if (!aresetn) gie <= 1'b0;
    else if (exec && alu_bus.op == OP_RET_INT) gie <= 1'b1;
    else if (wr_fire && sel_status) gie <= st_new[S_GIE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, return stack, memory
  always_ff @(posedge aclk) begin
    if (!aresetn) pc <= 12'h000;
    else if (exec && is_ret) pc <= stk_top;
    else if (exec && dec_skip) pc <= pc + 12'h002;
    else if (exec) pc <= pc + 12'h001;
    else if (wr_fire && sel_pc) pc <= pc_new[PCW-1:0];
  end

  // popping an empty stack yields address zero and leaves it empty
  always_ff @(posedge aclk) begin
    if (!aresetn) sp <= 4'h0;
    else if (exec && is_ret && !stk_empty) sp <= sp - 4'h1;
    else if (wr_fire && sel_stack && !stk_full) sp <= sp + 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (wr_fire && sel_stack && !stk_full && !exec)
      stk[3'(sp)] <= wdata_q[PCW-1:0];
  end

  always_ff @(posedge aclk) begin
    if (dm_we) dmem[dm_wa] <= dm_wd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) maddr <= 6'h00;
    else if (wr_fire && sel_maddr) maddr <= wdata_q[MAW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencing: dummy cycle for returns and taken skips
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_IDLE;
      cycles  <= 2'h0;
      skipped <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (exec) begin
          state   <= two_cyc ? ST_DUMMY : ST_IDLE;
          cycles  <= two_cyc ? CYC_TWO : CYC_ONE;
          skipped <= dec_skip;
        end
        ST_DUMMY: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exec_op(mlr_op_t o);
    exec && alu_bus.op == o;
  endsequence
  sequence s_skip_taken;
    exec && dec_skip;
  endsequence

  a_nop_pc_step: assert property (s_exec_op(OP_NOP) |=>
      pc == $past(pc) + 12'h001 && $stable(acc) && $stable(flag_c)
      && $stable(flag_z))
    else $error("nop changed state other than pc");
  a_ret_two_cyc: assert property (s_exec_op(OP_RET) |=>
      state == ST_DUMMY ##1 state == ST_IDLE)
    else $error("return did not take two cycles");
  a_ret_pops_pc: assert property ((exec && is_ret && !stk_empty) |=>
      pc == $past(stk_top) && sp == $past(sp) - 4'h1)
    else $error("return did not pop the stack");
  a_ret_int_gie: assert property (s_exec_op(OP_RET_INT) |=> gie)
    else $error("interrupt return left enable clear");
  a_mova_flags: assert property (s_exec_op(OP_MOV_A_M) |=>
      acc == $past(alu_bus.mem) && $stable({flag_c, flag_z, flag_sx}))
    else $error("move from memory wrong");
  a_or_zero_flag: assert property (s_exec_op(OP_OR_A_X) |=>
      flag_z == (acc == 8'h00) && acc == $past(acc | alu_bus.imm))
    else $error("or result or zero flag wrong");
  a_rl_c_carry: assert property (s_exec_op(OP_RL_C) |=>
      flag_c == $past(alu_bus.mem[7]) && $stable(acc))
    else $error("rotate through carry wrong");
  a_rr_ca_result: assert property (s_exec_op(OP_RR_CA) |=>
      acc == {$past(flag_c), $past(alu_bus.mem[7:1])})
    else $error("rotate right into accumulator wrong");
  a_sub_b_carry: assert property (s_exec_op(OP_SUB_B) |=>
      {flag_c, acc} == $past({1'b0, acc} + {1'b0, ~alu_bus.mem}
                             + {8'h00, flag_c}))
    else $error("subtract with borrow wrong");
  a_dec_skip_seq: assert property (s_skip_taken |=>
      state == ST_DUMMY && cycles == CYC_TWO && skipped ##1 idle)
    else $error("taken skip missed its dummy cycle");
  a_dec_no_skip: assert property ((exec && alu_bus.op == OP_DEC_SKZ
      && !dec_skip) |=> idle && cycles == CYC_ONE
      && pc == $past(pc) + 12'h001)
    else $error("untaken skip not one cycle");
endmodule : mlr_exec_core

/* File: mlr_exec_core_test.sv */
// self-checking bench: random operands through every opcode of the core
// assumes responses come in request order; a watchdog cuts a hang short
module mlr_exec_core_test;
  import mlr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } mlr_rexp_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  bq[$];
  mlr_rexp_t   rq[$];
  mlr_rexp_t   re;
  int          fails = 0;
  int          tests_run = 0;
  logic [7:0]  ea, em;
  logic        ec, eac, ez, eov, eg, esk;
  logic [11:0] epc;
  logic [1:0]  ecy;
  always #2 aclk = ~aclk;
  mlr_exec_core u_mlr_exec_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  mlr_axi_master u_mlr_axi_master (
    .aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
    .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input logic [3:0] s = 4'hF,
                   input logic [1:0] e = RESP_OKAY);
    bq.push_back(e);
    u_mlr_axi_master.wr(a, d, s);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] d,
                   input logic [31:0] m, input logic [1:0] e = RESP_OKAY);
    rq.push_back('{d, m, e});
    u_mlr_axi_master.rd(a);
  endtask : r
  // reference behaviour of one instruction on the expected state
  task automatic model(input logic [4:0] op, input logic [7:0] x,
                       input logic [11:0] top);
    logic [8:0] s;
    logic [4:0] lo;
    logic       ov;
    s = {1'b0, ea} + {1'b0, ~em} + {8'h00, ec};
    lo = {1'b0, ea[3:0]} + {1'b0, ~em[3:0]} + {4'h0, ec};
    ov = (ea[7] == ~em[7]) && (s[7] != ea[7]);
    epc = epc + 12'h001;
    ecy = CYC_ONE;
    esk = 1'b0;
    case (op)
      5'h00: ea = em;
      5'h01: ea = x;
      5'h02: em = ea;
      5'h04: begin ea = ea | em; ez = ~|ea; end
      5'h05: begin ea = ea | x; ez = ~|ea; end
      5'h06: begin em = ea | em; ez = ~|em; end
      5'h07, 5'h08, 5'h09: begin
        epc = top;
        ecy = CYC_TWO;
        if (op == 5'h08) ea = x;
        if (op == 5'h09) eg = 1'b1;
      end
      5'h0A: em = {em[6:0], em[7]};
      5'h0B: ea = {em[6:0], em[7]};
      5'h0C: {ec, em} = {em, ec};
      5'h0D: {ec, ea} = {em, ec};
      5'h0E: em = {em[0], em[7:1]};
      5'h0F: ea = {em[0], em[7:1]};
      5'h10: {em, ec} = {ec, em};
      5'h11: {ea, ec} = {ec, em};
      5'h12, 5'h13: begin
        if (op == 5'h12) ea = s[7:0];
        else em = s[7:0];
        {ec, eac, ez, eov} = {s[8], lo[4], ~|s[7:0], ov};
      end
      5'h14: begin
        em = em - 8'h01;
        if (em == 8'h00) {epc, ecy, esk} = {epc + 12'h001, CYC_TWO, 1'b1};
      end
      default: ;
    endcase
  endtask : model
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      check(s_axi_rdata & re.m, re.d & re.m);
      check({30'h0, s_axi_rresp}, {30'h0, re.r});
    end
  end
  initial begin
    #60_000;
    fails++;
    conclude();
  end
  initial begin
    logic [31:0] rnd;
    logic [4:0]  op;
    logic [5:0]  adr;
    logic [7:0]  x;
    logic [11:0] top;
    rnd = 32'h0001_29B9;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values; memory contents are not reset
    for (int i = 0; i < 8; i++) begin
      r(8'(i * 4), 32'h0, (i == 5) ? 32'h0 : (i == 2) ? 32'h31F : 32'hFFF);
    end
    for (int k = 0; k < 63; k++) begin
      op = 5'(k % 21);
      rnd = lfsr(rnd);
      {epc, eg, eov, ez, eac, ec, em, ea} = {rnd[31:20], rnd[20:0]};
      if (k == 20) em = 8'h01;
      adr = rnd[27:22];
      x = rnd[7:0] ^ rnd[31:24];
      top = ~epc;
      w(OFS_ACC, {24'h0, ea});
      w(OFS_STATUS, {27'h0, eg, eov, ez, eac, ec});
      w(OFS_PC, {20'h0, epc});
      w(OFS_MADDR, {26'h0, adr});
      w(OFS_MDATA, {24'h0, em});
      if (op inside {5'h07, 5'h08, 5'h09}) w(OFS_STACK, {20'h0, top});
      w(OFS_INSTR, {8'h0, x, 2'b00, adr, 3'b000, op});
      model(op, x, top);
      r(OFS_ACC, {24'h0, ea}, 32'h0000_00FF);
      r(OFS_STATUS, {22'h0, esk, 4'h0, eg, eov, ez, eac, ec}, 32'h31F);
      r(OFS_PC, {20'h0, epc}, 32'h0000_0FFF);
      r(OFS_MDATA, {24'h0, em}, 32'h0000_00FF);
      r(OFS_CYCLES, {30'h0, ecy}, 32'h0000_0003);
    end
    w(OFS_INSTR, 32'h0000_0015, 4'hF, RESP_SLVERR);
    w(OFS_ACC, 32'h0000_00FF, 4'h0);
    r(OFS_ACC, {24'h0, ea}, 32'h0000_00FF);
    w(8'h20, 32'h0, 4'hF, RESP_DECERR);
    r(8'h24, 32'h0, 32'h0, RESP_DECERR);
    conclude();
  end
endmodule : mlr_exec_core_test

/* File: mlr_pkg.sv */
// constants, opcode and state types for the move/logic/rotate execute core
// assumes one 250 MHz clock; used by the core, its datapath and interface
//
// Behaviour
// - move-from-memory copies the addressed byte to acc, no flags
// - move-immediate loads the 8-bit constant into the accumulator, no flags
// - move-to-memory stores the accumulator, accumulator and flags kept
// - no-operation only steps the program counter by one
// - OR with memory or immediate goes to the accumulator, only zero flag
// - OR-into-memory stores the OR back to memory, only zero flag
// - subroutine return pops the program counter, two cycles, no flags
// - return-with-value pops the counter, loads the constant into acc
// - interrupt return pops the counter and sets the global interrupt enable
// - in-place rotate left, bit 7 into bit 0, flags kept
// - rotate left into accumulator, memory byte kept
// - in-place rotate left via carry, old carry to bit 0, bit 7 to carry
// - rotate left through carry into accumulator, memory kept
// - in-place rotate right, bit 0 into bit 7, flags kept
// - rotate right into accumulator, memory byte kept
// - in-place rotate right via carry, old carry to bit 7, bit 0 to carry
// - rotate right through carry into accumulator, memory kept
// - subtract-with-borrow: acc plus inverted byte plus carry, four flags
// - same subtraction stored to memory, same four flags
// - decrement-skip-if-zero writes byte minus one, zero skips in two cycles, else one
package mlr_pkg;
  localparam int unsigned DW        = 8;
  localparam int unsigned PCW       = 12;
  localparam int unsigned MAW       = 6;
  localparam int unsigned DMEM_DEPTH = 64;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned SPW       = 4;
  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_MADDR  = 8'h10;
  localparam logic [7:0] OFS_MDATA  = 8'h14;
  localparam logic [7:0] OFS_STACK  = 8'h18;
  localparam logic [7:0] OFS_CYCLES = 8'h1C;
  // instruction word fields
  localparam int unsigned F_OP_LSB  = 0;
  localparam int unsigned F_ADR_LSB = 8;
  localparam int unsigned F_IMM_LSB = 16;
  // status bits
  localparam int unsigned S_C    = 0;
  localparam int unsigned S_HC   = 1;
  localparam int unsigned S_Z    = 2;
  localparam int unsigned S_SX   = 3;
  localparam int unsigned S_GIE  = 4;
  localparam int unsigned S_BUSY = 8;
  localparam int unsigned S_SKIP = 9;
  // machine cycle counts and bus response codes
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [4:0] {
    OP_MOV_A_M = 5'h00, OP_MOV_A_X = 5'h01, OP_MOV_M_A = 5'h02,
    OP_NOP     = 5'h03, OP_OR_A_M  = 5'h04, OP_OR_A_X  = 5'h05,
    OP_OR_M_A  = 5'h06, OP_RET     = 5'h07, OP_RET_A_X = 5'h08,
    OP_RET_INT = 5'h09, OP_RL      = 5'h0A, OP_RL_A    = 5'h0B,
    OP_RL_C    = 5'h0C, OP_RL_CA   = 5'h0D, OP_RR      = 5'h0E,
    OP_RR_A    = 5'h0F, OP_RR_C    = 5'h10, OP_RR_CA   = 5'h11,
    OP_SUB_B   = 5'h12, OP_SUB_B_M = 5'h13, OP_DEC_SKZ = 5'h14
  } mlr_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_DUMMY = 2'b10
  } mlr_state_t;
endpackage : mlr_pkg
